// ==== design/sps_top.sv ====
/*
  sps_top: start-up and power-down sequencer of the programmable device.
  Assumes core_clk is the configuration clock; pins from the board pass a synchroniser;
  the configuration memory and load engines sit outside and follow the grants here.
*/
// Implementation choices: the strobed register port and the register addresses.
// How it works
// R1: output disable released one clock after load-finished rises, by default.
// R2: write permit released one clock after output disable release, by default.
// R3: delays before each release are programmable, not fixed.
// R4: optionally hold both releases until every device's load-finished line is high.
// R5: optionally stall at a chosen step until clock managers and calibrator settle; here only lock steps 0 and 1 stall, step 2 does not.
// R6: readback only via byte-wide port (master or slave) or boundary scan.
// R7: readback covers flops, distributed memory and block memory with configuration.
// R8: partial reconfiguration only via slave byte-wide port or boundary scan.
// R9: partial frames write addressed area only, no chip reset, logic runs on.
// R10: partial data written frame by frame, one frame smallest unit.
// R11: sleep request low starts power-down into the inactive state.
// R12: with sleep-status option, load-finished pin shows asleep, cleared on wake.
// R13: asleep: only sleep and load-finished pins live, outputs hi-z, inputs off.
// R14: supply-drop reset deferred while asleep until sleep request released.
// R15: reprogram request ignored while asleep, sampled only after wake.
// R16: wake-up runs power-down steps in reverse order.
// R17: global flop reset pulsed after last frame, before start-up.
// R18: load-finished raised when configuration completes, starting start-up.
// R19: before release, outputs disabled and user storage frozen.
`timescale 1ns/1ps
`default_nettype none
module sps_top
(
  input wire logic core_clk,
  input wire logic sys_rst,
  input wire logic [3:0] reg_addr,
  input wire logic [31:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [31:0] reg_rdata,
  output logic irq,
  input wire logic sleep_request_n,
  input wire logic reprogram_request_n,
  input wire logic supply_low,
  input wire logic done_line_in,
  output logic done_line_out,
  output logic done_line_oe,
  input wire logic [3:0] clock_manager_locked,
  input wire logic impedance_calibrator_done,
  input wire logic [1:0] load_port,
  input wire logic last_frame_written,
  input wire logic frame_req,
  input wire logic [15:0] frame_addr,
  input wire logic readback_req,
  output sps_pkg::sps_cfg_req_t cfg_req,
  output logic readback_user_state,
  output logic global_output_disable,
  output logic global_write_permit,
  output logic global_flop_reset,
  output logic inputs_enable,
  output logic reconfig_request,
  output logic device_reset
);
  logic [31:0] ctrl_q;
  logic [3:0] od_dly_q;
  logic [3:0] wp_dly_q;
  logic [1:0] lock_step_q;
  logic [3:0] lock_sel_q;
  logic [sps_pkg::IRQ_W-1:0] irq_stat_q;
  logic [sps_pkg::IRQ_W-1:0] irq_mask_q;
  logic [sps_pkg::IRQ_W-1:0] irq_ev;
  sps_pkg::sps_state_t state_q;
  sps_pkg::sps_state_t state_d;
  logic [3:0] cnt_q;
  logic por_pend_q;
  logic [6:0] pins_s;
  logic sleep_n_s, prog_n_s, supply_low_s, done_all_s, last_frame_s, frame_s, rdbk_s;
  logic lock_ok, step_hold, cnt_done, rdbk_port_ok, part_port_ok;

  sps_sync #(.W(7), .INIT(7'h03)) sps_sync_inst
  (
    .core_clk(core_clk),
    .sys_rst(sys_rst),
    .d({readback_req, frame_req, last_frame_written, done_line_in,
        supply_low, reprogram_request_n, sleep_request_n}),
    .q(pins_s)
  );
  assign sleep_n_s = pins_s[0];
  assign prog_n_s = pins_s[1];
  assign supply_low_s = pins_s[2];
  assign done_all_s = pins_s[3];
  assign last_frame_s = pins_s[4];
  assign frame_s = pins_s[5];
  assign rdbk_s = pins_s[6];

  // port check used for both readback and partial load
  function automatic logic port_allowed(input logic [1:0] p, input logic slave_only);
    port_allowed = (p == sps_pkg::PORT_SCAN) || (p == sps_pkg::PORT_BYTE_SLAVE) ||
                   (!slave_only && p == sps_pkg::PORT_BYTE_MASTER);
  endfunction

  assign rdbk_port_ok = port_allowed(load_port, 1'b0); // [R6]
  assign part_port_ok = port_allowed(load_port, 1'b1); // [R8]

  // lock is ignored unless the option is set; selected managers plus calibrator
  assign lock_ok = !ctrl_q[sps_pkg::CTRL_WAIT_LOCK] ||
    (((clock_manager_locked & lock_sel_q) == lock_sel_q) && impedance_calibrator_done);
  assign cnt_done = (cnt_q <= 4'h1);

  // stall at the output or write-permit step when it is the selected lock step and lock is not ok, or the group is not all done; the run-step hold is unused
  always_comb
  begin
    step_hold = 1'b0;
    if (state_q == sps_pkg::ST_WAIT_OD)
    begin
      step_hold = (lock_step_q == 2'h0 && !lock_ok) ||
                  (ctrl_q[sps_pkg::CTRL_WAIT_ALL] && !done_all_s); // [R4] [R5]
    end
    else if (state_q == sps_pkg::ST_WAIT_WP)
    begin
      step_hold = (lock_step_q == 2'h1 && !lock_ok) ||
                  (ctrl_q[sps_pkg::CTRL_WAIT_ALL] && !done_all_s); // [R4] [R5]
    end
    else if (state_q == sps_pkg::ST_RUN)
    begin
      step_hold = (lock_step_q == 2'h2 && !lock_ok); // [R5]
    end
  end

  // sequencer next state
  always_comb
  begin
    state_d = state_q;
    case (state_q)
      sps_pkg::ST_LOAD:
        if (last_frame_s || ctrl_q[sps_pkg::CTRL_LOAD_DONE])
          state_d = sps_pkg::ST_GFR; // [R17]
      sps_pkg::ST_GFR:
        if (cnt_done)
          state_d = sps_pkg::ST_WAIT_OD; // [R18]
      sps_pkg::ST_WAIT_OD:
        if (cnt_done && !step_hold)
          state_d = sps_pkg::ST_WAIT_WP; // [R1] [R3]
      sps_pkg::ST_WAIT_WP:
        if (cnt_done && !step_hold)
          state_d = sps_pkg::ST_RUN; // [R2] [R3]
      sps_pkg::ST_RUN:
        if (!sleep_n_s)
          state_d = sps_pkg::ST_DOWN_WP; // [R11]
        else if (!prog_n_s || por_pend_q)
          state_d = sps_pkg::ST_LOAD;
      sps_pkg::ST_DOWN_WP:
        state_d = sps_pkg::ST_DOWN_OD;
      sps_pkg::ST_DOWN_OD:
        state_d = sps_pkg::ST_ASLEEP; // [R11]
      sps_pkg::ST_ASLEEP:
        if (sleep_n_s)
          state_d = sps_pkg::ST_WAKE; // [R15]
      sps_pkg::ST_WAKE:
        state_d = sps_pkg::ST_WAIT_OD; // [R16]
      default:
        state_d = sps_pkg::ST_LOAD;
    endcase
  end

  // state register
  always_ff @(posedge core_clk or posedge sys_rst)
  begin
    if (sys_rst)
      state_q <= sps_pkg::ST_LOAD;
    else
      state_q <= state_d;
  end

  // step counter reloads on entry to each timed step
  always_ff @(posedge core_clk or posedge sys_rst)
  begin
    if (sys_rst)
      cnt_q <= 4'h0;
    else if (state_d != state_q)
    begin
      if (state_d == sps_pkg::ST_GFR)
        cnt_q <= sps_pkg::GFR_CYC;
      else if (state_d == sps_pkg::ST_WAIT_OD)
        cnt_q <= od_dly_q; // [R3]
      else if (state_d == sps_pkg::ST_WAIT_WP)
        cnt_q <= wp_dly_q; // [R3]
      else
        cnt_q <= 4'h0;
    end
    else if (cnt_q != 4'h0)
      cnt_q <= cnt_q - 4'h1;
  end

  // supply drop while asleep is remembered, acted on only after wake
  always_ff @(posedge core_clk or posedge sys_rst)
  begin
    if (sys_rst)
      por_pend_q <= 1'b0;
    else if (supply_low_s)
      por_pend_q <= 1'b1; // [R14]
    else if (state_q == sps_pkg::ST_RUN && sleep_n_s)
      por_pend_q <= 1'b0;
  end

  // global controls from flops so they never glitch
  always_ff @(posedge core_clk or posedge sys_rst)
  begin
    if (sys_rst)
    begin
      global_output_disable <= 1'b1;
      global_write_permit <= 1'b0;
      global_flop_reset <= 1'b0;
      inputs_enable <= 1'b0;
      device_reset <= 1'b0;
      reconfig_request <= 1'b0;
    end
    else
    begin
      global_output_disable <= !(state_d == sps_pkg::ST_WAIT_WP ||
                                 state_d == sps_pkg::ST_RUN ||
                                 state_d == sps_pkg::ST_DOWN_WP); // [R1] [R13] [R19]
      global_write_permit <= (state_d == sps_pkg::ST_RUN); // [R2] [R19]
      global_flop_reset <= (state_d == sps_pkg::ST_GFR); // [R17]
      inputs_enable <= !(state_d == sps_pkg::ST_ASLEEP || state_d == sps_pkg::ST_DOWN_OD); // [R13]
      device_reset <= (state_q == sps_pkg::ST_RUN) && sleep_n_s && por_pend_q; // [R14]
      reconfig_request <= (state_q == sps_pkg::ST_RUN) && sleep_n_s && !prog_n_s; // [R15]
    end
  end

  // load-finished pin: done after configuration, or asleep status when option set
  always_ff @(posedge core_clk or posedge sys_rst)
  begin
    if (sys_rst)
    begin
      done_line_out <= 1'b0;
      done_line_oe <= 1'b0;
    end
    else if (ctrl_q[sps_pkg::CTRL_SLEEP_STAT] &&
             (state_q == sps_pkg::ST_DOWN_OD || state_q == sps_pkg::ST_ASLEEP ||
              state_q == sps_pkg::ST_DOWN_WP || state_q == sps_pkg::ST_WAKE))
    begin
      done_line_out <= (state_d == sps_pkg::ST_ASLEEP); // [R12]
      done_line_oe <= 1'b1;
    end
    else
    begin
      // open-drain style: held low through load and flop reset, so done rises
      // one step before the output release
      done_line_out <= 1'b0;
      done_line_oe <= (state_d == sps_pkg::ST_LOAD) ||
                      (state_d == sps_pkg::ST_GFR); // [R17] [R18]
    end
  end

  // frame writes and readback requests; partial writes never touch the reset path
  always_ff @(posedge core_clk or posedge sys_rst)
  begin
    if (sys_rst)
    begin
      cfg_req <= '0;
      readback_user_state <= 1'b0;
    end
    else
    begin
      cfg_req.frame_wr <= frame_s && (state_q == sps_pkg::ST_LOAD ||
        (state_q == sps_pkg::ST_RUN && ctrl_q[sps_pkg::CTRL_PARTIAL] && part_port_ok)); // [R8] [R10]
      cfg_req.partial <= (state_q == sps_pkg::ST_RUN); // [R9]
      cfg_req.frame_addr <= frame_addr; // [R10]
      cfg_req.readback <= rdbk_s && rdbk_port_ok && ctrl_q[sps_pkg::CTRL_READBACK]; // [R6]
      readback_user_state <= rdbk_s && rdbk_port_ok; // [R7]
    end
  end

  // interrupt events
  assign irq_ev[sps_pkg::IRQ_STARTED] = (state_q == sps_pkg::ST_WAIT_WP) &&
                                        (state_d == sps_pkg::ST_RUN);
  assign irq_ev[sps_pkg::IRQ_ASLEEP] = (state_d == sps_pkg::ST_ASLEEP) &&
                                       (state_q != sps_pkg::ST_ASLEEP);
  assign irq_ev[sps_pkg::IRQ_AWAKE] = (state_q == sps_pkg::ST_WAKE);
  assign irq_ev[sps_pkg::IRQ_REFUSED] = frame_s && (state_q == sps_pkg::ST_RUN) &&
                                        !part_port_ok;

  // configuration registers
  always_ff @(posedge core_clk or posedge sys_rst)
  begin
    if (sys_rst)
    begin
      ctrl_q <= sps_pkg::CTRL_RST;
      od_dly_q <= sps_pkg::OD_DLY_RST;
      wp_dly_q <= sps_pkg::WP_DLY_RST;
      lock_step_q <= sps_pkg::LOCK_STEP_RST;
      lock_sel_q <= 4'h0;
      irq_mask_q <= '0;
    end
    else if (reg_wr)
    begin
      if (reg_addr == sps_pkg::OFS_CTRL)
        ctrl_q <= reg_wdata;
      else if (reg_addr == sps_pkg::OFS_STEP)
      begin
        od_dly_q <= reg_wdata[sps_pkg::STEP_OD_LSB +: 4];
        wp_dly_q <= reg_wdata[sps_pkg::STEP_WP_LSB +: 4];
        lock_step_q <= reg_wdata[sps_pkg::STEP_LOCK_LSB +: 2];
        lock_sel_q <= reg_wdata[sps_pkg::STEP_LOCK_LSB + 4 +: 4];
      end
      else if (reg_addr == sps_pkg::OFS_IRQ_MASK)
        irq_mask_q <= reg_wdata[sps_pkg::IRQ_W-1:0];
    end
  end

  // sticky status: a new event wins over a same-cycle clear
  always_ff @(posedge core_clk or posedge sys_rst)
  begin
    if (sys_rst)
      irq_stat_q <= '0;
    else if (reg_wr && reg_addr == sps_pkg::OFS_IRQ_STAT)
      irq_stat_q <= (irq_stat_q & ~reg_wdata[sps_pkg::IRQ_W-1:0]) | irq_ev;
    else
      irq_stat_q <= irq_stat_q | irq_ev;
  end

  assign irq = |(irq_stat_q & irq_mask_q);

  // read data one cycle after the strobe; unmapped reads return zero
  always_ff @(posedge core_clk or posedge sys_rst)
  begin
    if (sys_rst)
      reg_rdata <= 32'h0000_0000;
    else if (!reg_rd)
      reg_rdata <= 32'h0000_0000;
    else if (reg_addr == sps_pkg::OFS_CTRL)
      reg_rdata <= ctrl_q;
    else if (reg_addr == sps_pkg::OFS_STEP)
      reg_rdata <= {16'h0000, lock_sel_q, 2'b00, lock_step_q, wp_dly_q, od_dly_q};
    else if (reg_addr == sps_pkg::OFS_STATUS)
      reg_rdata <= {18'h0_0000, por_pend_q, global_write_permit,
                    global_output_disable, 2'b00, state_q};
    else if (reg_addr == sps_pkg::OFS_IRQ_STAT)
      reg_rdata <= {28'h000_0000, irq_stat_q};
    else if (reg_addr == sps_pkg::OFS_IRQ_MASK)
      reg_rdata <= {28'h000_0000, irq_mask_q};
    else
      reg_rdata <= 32'h0000_0000;
  end

  // write permit only after outputs are enabled
  order_od_wp_a: assert property (@(posedge core_clk) disable iff (sys_rst)
    $rose(global_write_permit) |-> $past(!global_output_disable)) // [R2]
    else $error("write permit released before output enable");
  // default spacing: one clock after done, then one more
  default_seq_a: assert property (@(posedge core_clk) disable iff (sys_rst)
    (state_q == sps_pkg::ST_WAIT_OD && $past(state_q) == sps_pkg::ST_GFR &&
     od_dly_q == 4'h1 && wp_dly_q == 4'h1 && !step_hold && !ctrl_q[sps_pkg::CTRL_WAIT_ALL])
    |=> !global_output_disable ##1 global_write_permit) // [R1]
    else $error("default start-up spacing wrong");
  // group wait holds output disable
  group_wait_a: assert property (@(posedge core_clk) disable iff (sys_rst)
    (state_q == sps_pkg::ST_WAIT_OD && ctrl_q[sps_pkg::CTRL_WAIT_ALL] && !done_all_s)
    |=> state_q != sps_pkg::ST_WAIT_WP) // [R4]
    else $error("released without all done lines");
  // lock stall
  lock_stall_a: assert property (@(posedge core_clk) disable iff (sys_rst)
    (state_q == sps_pkg::ST_WAIT_OD && lock_step_q == 2'h0 && !lock_ok)
    |=> state_q == sps_pkg::ST_WAIT_OD) // [R5]
    else $error("lock stall ignored");
  // asleep means outputs off and inputs off
  asleep_pins_a: assert property (@(posedge core_clk) disable iff (sys_rst)
    state_q == sps_pkg::ST_ASLEEP |-> global_output_disable && !inputs_enable) // [R13]
    else $error("pins active while asleep");
  // no reset or reprogram while asleep
  sleep_noreset_a: assert property (@(posedge core_clk) disable iff (sys_rst)
    state_q == sps_pkg::ST_ASLEEP |=> !device_reset && !reconfig_request) // [R14]
    else $error("reset while asleep");
  // sleep request leads to asleep within three cycles
  sleep_entry_a: assert property (@(posedge core_clk) disable iff (sys_rst)
    (state_q == sps_pkg::ST_RUN && !sleep_n_s) |-> ##[1:3] state_q == sps_pkg::ST_ASLEEP) // [R11]
    else $error("power-down not entered");
  // wake goes back through output release before write permit
  wake_order_a: assert property (@(posedge core_clk) disable iff (sys_rst)
    state_q == sps_pkg::ST_WAKE |=> state_q == sps_pkg::ST_WAIT_OD) // [R16]
    else $error("wake order wrong");
  // global flop reset pulse precedes start-up
  gfr_pulse_a: assert property (@(posedge core_clk) disable iff (sys_rst)
    $rose(global_flop_reset) |-> !global_write_permit ##1 global_flop_reset) // [R17]
    else $error("flop reset pulse wrong");
  // partial frame only from allowed ports
  partial_port_a: assert property (@(posedge core_clk) disable iff (sys_rst)
    (cfg_req.frame_wr && cfg_req.partial) |-> $past(part_port_ok)) // [R8]
    else $error("partial frame from wrong port");

  startup_c: cover property (@(posedge core_clk) disable iff (sys_rst) $rose(global_write_permit));
  sleep_c: cover property (@(posedge core_clk) disable iff (sys_rst)
    state_q == sps_pkg::ST_ASLEEP ##1 state_q == sps_pkg::ST_WAKE);
  partial_c: cover property (@(posedge core_clk) disable iff (sys_rst)
    cfg_req.frame_wr && cfg_req.partial);
endmodule
`default_nettype wire

// ==== design/sps_pkg.sv ====
/*
  sps_pkg: constants, states and carriers for the start-up / power-down sequencer.
  Assumes one clock (core_clk, 50 MHz) and an asynchronous active-high reset.
*/
package sps_pkg;
  // register offsets (word addresses on the plain register port)
  localparam logic [3:0] OFS_CTRL = 4'h0;
  localparam logic [3:0] OFS_STEP = 4'h1;
  localparam logic [3:0] OFS_STATUS = 4'h2;
  localparam logic [3:0] OFS_IRQ_STAT = 4'h3;
  localparam logic [3:0] OFS_IRQ_MASK = 4'h4;
  localparam logic [3:0] OFS_LOAD = 4'h5;
  // control field positions
  localparam int CTRL_WAIT_ALL = 0;
  localparam int CTRL_WAIT_LOCK = 1;
  localparam int CTRL_SLEEP_STAT = 2;
  localparam int CTRL_LOAD_DONE = 3;
  localparam int CTRL_PARTIAL = 4;
  localparam int CTRL_READBACK = 5;
  // step register: cycles before each release and the step where lock is awaited
  localparam int STEP_OD_LSB = 0;
  localparam int STEP_WP_LSB = 4;
  localparam int STEP_LOCK_LSB = 8;
  localparam logic [31:0] CTRL_RST = 32'h0000_0000;
  localparam logic [3:0] OD_DLY_RST = 4'h1;
  localparam logic [3:0] WP_DLY_RST = 4'h1;
  localparam logic [1:0] LOCK_STEP_RST = 2'h1;
  // irq bit positions
  localparam int IRQ_STARTED = 0;
  localparam int IRQ_ASLEEP = 1;
  localparam int IRQ_AWAKE = 2;
  localparam int IRQ_REFUSED = 3;
  localparam int IRQ_W = 4;
  // global reset pulse length
  localparam int GFR_NS = 40;
  localparam int CLK_NS = 20;
  localparam logic [3:0] GFR_CYC = 4'((GFR_NS + CLK_NS - 1) / CLK_NS);
  // load ports
  localparam logic [1:0] PORT_SERIAL = 2'h0;
  localparam logic [1:0] PORT_BYTE_MASTER = 2'h1;
  localparam logic [1:0] PORT_BYTE_SLAVE = 2'h2;
  localparam logic [1:0] PORT_SCAN = 2'h3;

  typedef enum logic [8:0] {
    ST_LOAD = 9'h001,
    ST_GFR = 9'h002,
    ST_WAIT_OD = 9'h004,
    ST_WAIT_WP = 9'h008,
    ST_RUN = 9'h010,
    ST_DOWN_WP = 9'h020,
    ST_DOWN_OD = 9'h040,
    ST_ASLEEP = 9'h080,
    ST_WAKE = 9'h100
  } sps_state_t;

  // request to the configuration memory for a frame or readback
  typedef struct packed {
    logic frame_wr;
    logic partial;
    logic readback;
    logic [15:0] frame_addr;
  } sps_cfg_req_t;
endpackage

// ==== design/sps_sync.sv ====
/*
  sps_sync: two-stage synchroniser for asynchronous pins.
  Assumes the destination clock is core_clk; the first stage feeds only the second.
*/
`timescale 1ns/1ps
`default_nettype none
module sps_sync #(
  parameter int W = 1,
  parameter logic [W-1:0] INIT = '0
)
(
  input wire logic core_clk,
  input wire logic sys_rst,
  input wire logic [W-1:0] d,
  output logic [W-1:0] q
);
  logic [W-1:0] meta_q;

  // constant reset; pins are unknown until the first edges
  always_ff @(posedge core_clk or posedge sys_rst)
  begin
    if (sys_rst)
    begin
      meta_q <= INIT;
      q <= INIT;
    end
    else
    begin
      meta_q <= d;
      q <= meta_q;
    end
  end
endmodule
`default_nettype wire

// ==== verif/sps_board_model.sv ====
/*
  sps_board_model: board controller at the far side of the sequencer.
  Assumes the bench commands sleep and a second device's hold on the load-finished line.
*/
`timescale 1ns/1ps
`default_nettype none
module sps_board_model
(
  input wire logic core_clk,
  input wire logic sleep_cmd,
  input wire logic other_hold,
  input wire logic done_line_out,
  input wire logic done_line_oe,
  output logic sleep_request_n,
  output logic done_line_in
);
  // sleep line moves only just after an edge, as a board controller would
  initial sleep_request_n = 1'b1;
  always @(posedge core_clk)
    sleep_request_n <= !sleep_cmd;
  // wired load-finished line: pulled high, any driver of a low wins
  assign done_line_in = !(done_line_oe && !done_line_out) && !other_hold;
endmodule
`default_nettype wire

// ==== verif/test_sps_top.sv ====
/*
  test_sps_top: register-port and pin-level tests of the start-up / power-down sequencer.
  Assumes sps_top and sps_board_model are compiled first; one 50 MHz clock.
*/
`timescale 1ns/1ps
`default_nettype none
module test_sps_top;
  logic core_clk, sys_rst, reg_wr, reg_rd, irq, sleep_cmd, other_hold, sleep_request_n;
  logic reprogram_request_n, supply_low, done_line_in, done_line_out, done_line_oe;
  logic impedance_calibrator_done, last_frame_written, frame_req, readback_req;
  logic readback_user_state, global_output_disable, global_write_permit, global_flop_reset;
  logic inputs_enable, reconfig_request, device_reset, seen_rb, seen_us, seen_gfr, fw_prev;
  logic [3:0] reg_addr, clock_manager_locked;
  logic [31:0] reg_wdata, reg_rdata, rdv;
  logic [1:0] load_port;
  logic [15:0] frame_addr, last_fa;
  sps_pkg::sps_cfg_req_t cfg_req;
  int mismatches, num_checks, n, fw_cnt;

  sps_top sps_top_inst (.core_clk(core_clk), .sys_rst(sys_rst), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .irq(irq),
    .sleep_request_n(sleep_request_n), .reprogram_request_n(reprogram_request_n),
    .supply_low(supply_low), .done_line_in(done_line_in), .done_line_out(done_line_out),
    .done_line_oe(done_line_oe), .clock_manager_locked(clock_manager_locked),
    .impedance_calibrator_done(impedance_calibrator_done), .load_port(load_port),
    .last_frame_written(last_frame_written), .frame_req(frame_req), .frame_addr(frame_addr),
    .readback_req(readback_req), .cfg_req(cfg_req), .readback_user_state(readback_user_state),
    .global_output_disable(global_output_disable), .global_write_permit(global_write_permit),
    .global_flop_reset(global_flop_reset), .inputs_enable(inputs_enable),
    .reconfig_request(reconfig_request), .device_reset(device_reset));
  sps_board_model sps_board_model_inst (.core_clk(core_clk), .sleep_cmd(sleep_cmd),
    .other_hold(other_hold), .done_line_out(done_line_out), .done_line_oe(done_line_oe),
    .sleep_request_n(sleep_request_n), .done_line_in(done_line_in));

  // free-running configuration clock
  initial
  begin
    core_clk = 1'b0;
    forever #10 core_clk = ~core_clk;
  end

  // sticky observations of the configuration-memory requests
  always @(posedge core_clk)
  begin
    if (cfg_req.readback === 1'b1) seen_rb = 1'b1;
    if (cfg_req.readback === 1'b1 && readback_user_state === 1'b1) seen_us = 1'b1;
    if (cfg_req.frame_wr === 1'b1 && !fw_prev) fw_cnt++;
    if (cfg_req.frame_wr === 1'b1) last_fa = cfg_req.frame_addr;
    fw_prev = (cfg_req.frame_wr === 1'b1);
    if (global_flop_reset === 1'b1) seen_gfr = 1'b1;
  end

  task test_done;
    $display("checks %0d mismatches %0d", num_checks, mismatches);
    if (mismatches == 0 && num_checks > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask

  task chk(input logic [31:0] seen, input logic [31:0] exp);
    num_checks++;
    if (seen !== exp)
    begin
      mismatches++;
      $display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask

  function logic probe(input int k);
    case (k)
      0: probe = global_output_disable;
      1: probe = global_write_permit;
      2: probe = inputs_enable;
      3: probe = global_flop_reset;
      4: probe = done_line_oe;
      5: probe = device_reset;
      default: probe = reconfig_request;
    endcase
  endfunction

  // bounded wait; cnt is the number of edges it took
  task wait_lvl(input int k, input logic v, output int cnt);
    cnt = 0;
    while (probe(k) !== v && cnt < 40)
    begin
      @(posedge core_clk);
      #1;
      cnt++;
    end
    if (probe(k) !== v)
    begin
      mismatches++;
      $display("MISMATCH t=%0t wait %0d seen=%h exp=%h", $time, k, probe(k), v);
      test_done;
    end
  endtask

  task wr(input logic [3:0] a, input logic [31:0] d);
    @(posedge core_clk);
    reg_wr <= 1'b1;
    reg_addr <= a;
    reg_wdata <= d;
    @(posedge core_clk);
    reg_wr <= 1'b0;
  endtask

  // read data stands only in the cycle after the strobe
  task rd(input logic [3:0] a, output logic [31:0] d);
    @(posedge core_clk);
    reg_rd <= 1'b1;
    reg_addr <= a;
    @(posedge core_clk);
    reg_rd <= 1'b0;
    #1;
    d = reg_rdata;
  endtask

  task do_reset;
    @(posedge core_clk);
    sys_rst <= 1'b1;
    last_frame_written <= 1'b0;
    sleep_cmd <= 1'b0;
    other_hold <= 1'b0;
    supply_low <= 1'b0;
    reprogram_request_n <= 1'b1;
    repeat (8) @(posedge core_clk);
    sys_rst <= 1'b0;
    @(posedge core_clk);
    #1;
  endtask

  // full start-up; bit3 of ctrl chooses the software load-done path
  task startup(input logic [31:0] ctrl, input logic [31:0] step);
    do_reset;
    chk({global_output_disable, global_write_permit}, 2'b10);
    wr(sps_pkg::OFS_STEP, step);
    wr(sps_pkg::OFS_CTRL, ctrl);
    @(posedge core_clk);
    last_frame_written <= !ctrl[sps_pkg::CTRL_LOAD_DONE];
    #1;
    wait_lvl(3, 1'b1, n);
    wait_lvl(3, 1'b0, n);
    chk(n, sps_pkg::GFR_CYC);
    wait_lvl(4, 1'b0, n);
    chk(done_line_in, 1'b1);
    wait_lvl(0, 1'b0, n);
    chk(n, step[3:0]);
    wait_lvl(1, 1'b1, n);
    chk(n, step[7:4]);
  endtask

  // start-up held by another device's load-finished line or by lock
  task stall_run(input logic [31:0] ctrl, input logic [31:0] step);
    do_reset;
    wr(sps_pkg::OFS_STEP, step);
    wr(sps_pkg::OFS_CTRL, ctrl);
    @(posedge core_clk);
    other_hold <= ctrl[sps_pkg::CTRL_WAIT_ALL];
    clock_manager_locked <= 4'h0;
    impedance_calibrator_done <= 1'b0;
    last_frame_written <= 1'b1;
    wait_lvl(4, 1'b0, n);
    repeat (12) @(posedge core_clk);
    #1;
    chk({global_output_disable, global_write_permit}, 2'b10);
    @(posedge core_clk);
    other_hold <= 1'b0;
    clock_manager_locked <= 4'hf;
    impedance_calibrator_done <= 1'b1;
    wait_lvl(0, 1'b0, n);
    wait_lvl(1, 1'b1, n);
  endtask

  initial
  begin
    sys_rst = 1'b1;
    {reg_wr, reg_rd, sleep_cmd, other_hold, supply_low, frame_req, readback_req} = '0;
    {last_frame_written, seen_rb, seen_us, seen_gfr, fw_prev} = '0;
    reprogram_request_n = 1'b1;
    impedance_calibrator_done = 1'b1;
    {reg_addr, reg_wdata, load_port, frame_addr, last_fa} = '0;
    clock_manager_locked = 4'hf;
    do_reset;
    rd(sps_pkg::OFS_STEP, rdv);
    chk(rdv, {22'h0, sps_pkg::LOCK_STEP_RST, sps_pkg::WP_DLY_RST, sps_pkg::OD_DLY_RST});
    rd(sps_pkg::OFS_CTRL, rdv);
    chk(rdv, sps_pkg::CTRL_RST);
    rd(4'hf, rdv);
    chk(rdv, 32'h0000_0000);
    $display("test reset values done");
    startup(32'h0000_0000, 32'h0000_0111);
    rd(sps_pkg::OFS_STATUS, rdv);
    chk(rdv, {18'h0_0000, 3'b010, 2'b00, sps_pkg::ST_RUN});
    startup(32'h0000_0008, 32'h0000_0132);
    $display("test start-up order done");
    stall_run(32'h0000_0001, 32'h0000_0111);
    stall_run(32'h0000_0002, 32'h0000_1011);
    $display("test start-up stalls done");
    // sleep with status option, then faults while asleep, then wake
    startup(32'h0000_0004, 32'h0000_0111);
    wr(sps_pkg::OFS_IRQ_MASK, 32'h0000_0002);
    @(posedge core_clk);
    sleep_cmd <= 1'b1;
    wait_lvl(1, 1'b0, n);
    wait_lvl(0, 1'b1, n);
    chk(n, 1);
    wait_lvl(2, 1'b0, n);
    repeat (4) @(posedge core_clk);
    #1;
    chk({done_line_in, irq}, 2'b11);
    @(posedge core_clk);
    supply_low <= 1'b1;
    reprogram_request_n <= 1'b0;
    repeat (10) @(posedge core_clk);
    #1;
    chk({device_reset, reconfig_request, global_output_disable, inputs_enable}, 4'h2);
    rd(sps_pkg::OFS_IRQ_STAT, rdv);
    chk(rdv, 32'h0000_0003);
    wr(sps_pkg::OFS_IRQ_STAT, 32'h0000_0002);
    rd(sps_pkg::OFS_IRQ_STAT, rdv);
    chk(rdv, 32'h0000_0001);
    chk(irq, 1'b0);
    @(posedge core_clk);
    sleep_cmd <= 1'b0;
    wait_lvl(0, 1'b0, n);
    wait_lvl(1, 1'b1, n);
    chk(n, 1);
    wait_lvl(6, 1'b1, n);
    wait_lvl(5, 1'b1, n);
    $display("test sleep and wake done");
    // each load port tries a partial frame and a readback
    startup(32'h0000_0030, 32'h0000_0111);
    for (int p = 0; p < 4; p++)
    begin
      @(posedge core_clk);
      load_port <= p[1:0];
      frame_addr <= 16'h0100 + 16'(p);
      repeat (2) @(posedge core_clk);
      #1;
      {seen_rb, seen_us, seen_gfr} = '0;
      fw_cnt = 0;
      @(posedge core_clk);
      frame_req <= 1'b1;
      repeat (4) @(posedge core_clk);
      frame_req <= 1'b0;
      readback_req <= 1'b1;
      repeat (4) @(posedge core_clk);
      readback_req <= 1'b0;
      repeat (8) @(posedge core_clk);
      #1;
      chk(seen_rb, p != 0);
      chk(seen_us, p != 0);
      chk(fw_cnt, (p >= 2) ? 1 : 0);
      chk({seen_gfr, global_output_disable, global_write_permit}, 3'b001);
      if (p >= 2)
        chk(last_fa, 16'h0100 + 16'(p));
    end
    rd(sps_pkg::OFS_IRQ_STAT, rdv);
    chk(rdv, 32'h0000_0009);
    $display("test partial and readback done");
    test_done;
  end
endmodule
`default_nettype wire
